// >>> src/mrma_map.vh
// register map constants for the modbus register-map access block
`ifndef MRMA_MAP_VH
`define MRMA_MAP_VH
`define MRMA_ADDR_ANALOG_BASE   16'h0000
`define MRMA_ANALOG_COUNT       9'h0FF
`define MRMA_ADDR_TEST          16'hD73C
`define MRMA_TEST_VALUE         32'h00112233
`define MRMA_ADDR_PATH_BUF      16'hECEC
`define MRMA_ADDR_PATH_NEXT     16'hECEE
`define MRMA_ADDR_PATH_LEN      16'hECF0
`define MRMA_ADDR_PATH_GO       16'hECF2
`define MRMA_ADDR_CTRL          16'hECF4
`define MRMA_ADDR_STATUS        16'hECF6
`define MRMA_CTRL_RESET         16'h0000
`define MRMA_STAT_LEN_POS       0
`define MRMA_STAT_DONE_POS      15
`endif

// >>> src/mrma_byte_order.v
// splits a 16-bit word into two bytes, most significant first
`default_nettype none
module mrma_byte_order
(
  input  wire        core_clk,
  input  wire        reset_n,
  input  wire        load,
  input  wire [15:0] word_in,
  input  wire        take,
  output reg  [7:0]  byte_out,
  output reg         byte_valid
);
  reg [7:0] low_byte;
  reg       low_pending;
  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      byte_out    <= 8'h00;
      byte_valid  <= 1'b0;
      low_byte    <= 8'h00;
      low_pending <= 1'b0;
    end
    else if (load)
    begin
      byte_out    <= word_in[15:8];
      byte_valid  <= 1'b1;
      low_byte    <= word_in[7:0];
      low_pending <= 1'b1;
    end
    else if (take && low_pending)
    begin
      byte_out    <= low_byte;
      low_pending <= 1'b0;
    end
    else if (take)
      byte_valid <= 1'b0;
  end
endmodule // mrma_byte_order
`default_nettype wire

// >>> src/mrma_seq_buffer.v
// sequential-only buffer register storage
`default_nettype none
module mrma_seq_buffer
#(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
)
(
  input  wire             core_clk,
  input  wire             reset_n,
  input  wire             clear,
  input  wire             push,
  input  wire [WIDTH-1:0] push_data,
  input  wire             pop,
  output wire [WIDTH-1:0] pop_data,
  output reg  [AW:0]      count
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  wire            do_push = push && (count != DEPTH[AW:0]);
  wire            do_pop  = pop && (count != {(AW+1){1'b0}});
  assign pop_data = mem[rd_ptr];
  always @(posedge core_clk)
  begin
    if (do_push)
      mem[wr_ptr] <= push_data;
  end
  always @(posedge core_clk)
  begin
    if (!reset_n || clear)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_push)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_pop)
        rd_ptr <= rd_ptr + 1'b1;
      count <= count + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
    end
  end
endmodule // mrma_seq_buffer
`default_nettype wire

// >>> src/mrma_top.v
// modbus register-map access: word decode, buffer register, byte order
// What this block does
// - packet address used exactly, 0 to 65535
// - one flat decode for all register kinds
// - single word returned high byte first
// - 32-bit value: high word at lower address
// - test pair at 55100 reads 0x00112233
// - channel address is base plus index times width
// - each location holds one 16-bit word
// - 255 float inputs from address 0
// - buffer read repeats at its one address
// - buffer write appends each word in order until full, then drops
// - read at 60652 never reaches 60654
// - buffer access strictly sequential, no overwrite
// - everything reached only through register access
`include "mrma_map.vh"
`default_nettype none
module mrma_top
#(
  parameter BUF_DEPTH = 16,
  parameter BUF_AW    = 4
)
(
  input  wire         core_clk,
  input  wire         reset_n,
  input  wire         req_valid,
  input  wire         req_write,
  input  wire [15:0]  req_addr,
  input  wire [7:0]   req_count,
  input  wire [15:0]  req_wdata,
  input  wire         wdata_valid,
  input  wire         byte_take,
  output reg          req_ready,
  output reg  [15:0]  rsp_word,
  output reg          rsp_valid,
  output reg          rsp_error,
  output wire [7:0]   rsp_byte,
  output wire         rsp_byte_valid,
  output reg          analog_sel_valid,
  output reg  [7:0]   analog_sel_index,
  input  wire [31:0]  analog_input_value,
  output reg          path_go,
  output reg  [15:0]  path_length
);
  localparam ST_IDLE = 2'b00;
  localparam ST_READ = 2'b01;
  localparam ST_WRIT = 2'b10;
  localparam [15:0] TEST_ADDR  = `MRMA_ADDR_TEST;
  localparam [31:0] TEST_VALUE = `MRMA_TEST_VALUE;
  reg  [1:0]  state;
  reg  [15:0] cur_addr;
  reg  [7:0]  words_left;
  reg  [15:0] ctrl_reg;
  reg  [15:0] next_word;
  reg         next_err;
  reg         next_advance;
  reg         buf_push;
  reg         buf_pop;
  reg         buf_clear;
  reg         done_flag;
  wire [15:0] buf_data;
  wire [BUF_AW:0] buf_count;
  wire        is_analog;
  wire [15:0] next_addr;
  wire        is_buf;
  wire        is_go;
  wire        is_len;
  wire        is_ctrl;
  wire        is_stat;
  wire        is_test;

  // flat decode over full 16-bit space, no offset applied
  assign is_analog = cur_addr < {6'h00, `MRMA_ANALOG_COUNT, 1'b0};
  assign next_addr = cur_addr + 16'h0001;
  assign is_test   = cur_addr[15:1] == TEST_ADDR[15:1];
  assign is_buf    = cur_addr == `MRMA_ADDR_PATH_BUF;
  assign is_len    = cur_addr == `MRMA_ADDR_PATH_LEN;
  assign is_go     = cur_addr == `MRMA_ADDR_PATH_GO;
  assign is_ctrl   = cur_addr == `MRMA_ADDR_CTRL;
  assign is_stat   = cur_addr == `MRMA_ADDR_STATUS;

  mrma_seq_buffer
  #(
    .WIDTH (16),
    .DEPTH (BUF_DEPTH),
    .AW    (BUF_AW)
  )
  u_buf
  (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .clear     (buf_clear),
    .push      (buf_push),
    .push_data (req_wdata),
    .pop       (buf_pop),
    .pop_data  (buf_data),
    .count     (buf_count)
  );

  mrma_byte_order u_bytes
  (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .load       (rsp_valid),
    .word_in    (rsp_word),
    .take       (byte_take),
    .byte_out   (rsp_byte),
    .byte_valid (rsp_byte_valid)
  );

  // read data select, one 16-bit word per location
  always @*
  begin
    next_word = 16'h0000;
    next_err  = 1'b0;
    buf_pop   = 1'b0;
    if (is_analog)
      next_word = cur_addr[0] ? analog_input_value[15:0] : analog_input_value[31:16];
    else if (is_test)
      next_word = cur_addr[0] ? TEST_VALUE[15:0] : TEST_VALUE[31:16];
    else if (is_buf)
    begin
      next_word = buf_data;
      buf_pop   = (state == ST_READ);
    end
    else if (is_len)
      next_word = path_length;
    else if (is_ctrl)
      next_word = ctrl_reg;
    else if (is_stat)
      next_word = {done_flag, {(15-BUF_AW-1){1'b0}}, buf_count};
    else
      next_err = 1'b1;
  end

  always @*
  begin
    buf_push  = (state == ST_WRIT) && wdata_valid && is_buf;
    buf_clear = (state == ST_WRIT) && wdata_valid && is_len;
    next_advance = !is_buf;
  end

  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      state         <= ST_IDLE;
      cur_addr      <= 16'h0000;
      words_left    <= 8'h00;
      req_ready     <= 1'b1;
      rsp_word      <= 16'h0000;
      rsp_valid     <= 1'b0;
      rsp_error     <= 1'b0;
      analog_sel_valid <= 1'b0;
      analog_sel_index <= 8'h00;
      path_go       <= 1'b0;
      path_length   <= 16'h0000;
      ctrl_reg      <= `MRMA_CTRL_RESET;
      done_flag     <= 1'b0;
    end
    else
    begin
      rsp_valid     <= 1'b0;
      path_go       <= 1'b0;
      analog_sel_valid <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (req_valid && req_count != 8'h00)
          begin
            cur_addr   <= req_addr;
            analog_sel_index <= req_addr[8:1];
            words_left <= req_count;
            req_ready  <= 1'b0;
            rsp_error  <= 1'b0;
            state      <= req_write ? ST_WRIT : ST_READ;
          end
        end
        ST_READ:
        begin
          rsp_word      <= next_word;
          rsp_valid     <= 1'b1;
          rsp_error     <= rsp_error | next_err;
          analog_sel_valid <= is_analog;
          if (next_advance)
          begin
            cur_addr         <= next_addr;
            analog_sel_index <= next_addr[8:1];
          end
          words_left <= words_left - 8'h01;
          if (words_left == 8'h01)
          begin
            state     <= ST_IDLE;
            req_ready <= 1'b1;
          end
        end
        ST_WRIT:
        begin
          if (wdata_valid)
          begin
            if (is_len)
              path_length <= req_wdata;
            else if (is_ctrl)
              ctrl_reg <= req_wdata;
            else if (is_go)
              path_go <= 1'b1;
            else if (!is_buf)
              rsp_error <= 1'b1;
            if (is_go)
              done_flag <= 1'b1;
            else if (is_len)
              done_flag <= 1'b0;
            if (next_advance)
              cur_addr <= cur_addr + 16'h0001;
            words_left <= words_left - 8'h01;
            if (words_left == 8'h01)
            begin
              state     <= ST_IDLE;
              req_ready <= 1'b1;
            end
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end
endmodule // mrma_top
`default_nettype wire

// >>> bench/mrma_monitor.sv
// assertions on mrma_top ports
`default_nettype none
module mrma_monitor
(
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        req_valid,
  input wire logic        req_write,
  input wire logic [15:0] req_addr,
  input wire logic [7:0]  req_count,
  input wire logic        wdata_valid,
  input wire logic        req_ready,
  input wire logic [15:0] rsp_word,
  input wire logic        rsp_valid,
  input wire logic        rsp_error,
  input wire logic [7:0]  rsp_byte,
  input wire logic        analog_sel_valid,
  input wire logic [7:0]  analog_sel_index,
  input wire logic        path_go,
  input wire logic [15:0] path_length
);
  timeunit 1ns;
  timeprecision 1ns;
  wire rd = req_valid && req_ready && req_count != 8'h00 && !req_write;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_first; rd |=> ##1 rsp_valid; endproperty
  a_first: assert property (p_first) else $error("no first word");
  property p_hi; rd && req_addr == 16'hD73C |=> ##1 rsp_valid && rsp_word == 16'h0011; endproperty
  a_hi: assert property (p_hi) else $error("bad high word");
  property p_lo; rd && req_addr == 16'hD73C && req_count > 8'h01 |=> ##2 rsp_valid && rsp_word == 16'h2233; endproperty
  a_lo: assert property (p_lo) else $error("bad low word");
  property p_msb; rsp_valid |=> {8'h00, rsp_byte} == $past(rsp_word) >> 8; endproperty
  a_msb: assert property (p_msb) else $error("bad first byte");
  property p_analog; rd && req_addr < 16'h01FE |=> ({8'h00, analog_sel_index} == ($past(req_addr) >> 1)) ##1
    analog_sel_valid;
  endproperty
  a_analog: assert property (p_analog) else $error("bad channel");
  property p_go; path_go |=> !path_go; endproperty
  a_go: assert property (p_go) else $error("long go pulse");
  property p_len; !$stable(path_length) |-> $past(wdata_valid); endproperty
  a_len: assert property (p_len) else $error("length moved alone");
  property p_buf; rd && req_addr == 16'hECEC |=> ##1 !rsp_error; endproperty
  a_buf: assert property (p_buf) else $error("buffer read error");
endmodule // mrma_monitor
bind mrma_top mrma_monitor u_mon (.core_clk, .reset_n, .req_valid, .req_write, .req_addr, .req_count,
  .wdata_valid, .req_ready, .rsp_word, .rsp_valid, .rsp_error, .rsp_byte, .analog_sel_valid, .analog_sel_index,
  .path_go, .path_length);
`default_nettype wire

// >>> bench/mrma_ain_src.sv
// analog value source model
`default_nettype none
module mrma_analog_src
#(
  parameter logic [31:0] VALUE = 32'h3F801234
)
(
  input  wire logic [7:0]  chan_index,
  output logic      [31:0] analog_input_value
);
  timeunit 1ns;
  timeprecision 1ns;
  // each channel shows its own value so word order across channels is visible
  assign analog_input_value = VALUE + {24'h000000, chan_index};
endmodule // mrma_analog_src
`default_nettype wire

// >>> bench/test_mrma_top.sv
// testbench for mrma_top
`default_nettype none
module test_mrma_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] AV  = 32'h3F801234;
  localparam logic [31:0] AV1 = AV + 32'h00000001;
  logic        core_clk, reset_n, req_valid, req_write, wdata_valid, byte_take;
  logic [15:0] req_addr, req_wdata, rsp_word, path_length, rnd;
  logic [7:0]  req_count, rsp_byte, analog_sel_index;
  logic        req_ready, rsp_valid, rsp_error, rsp_byte_valid, analog_sel_valid, path_go;
  logic [31:0] analog_input_value;
  logic [15:0] exp_q[$];
  int          n_fail, n_checks, n_go, cyc, i;
  mrma_top #(.BUF_DEPTH(4), .BUF_AW(2)) uut
  (
    .core_clk           (core_clk),
    .reset_n            (reset_n),
    .req_valid          (req_valid),
    .req_write          (req_write),
    .req_addr           (req_addr),
    .req_count          (req_count),
    .req_wdata          (req_wdata),
    .wdata_valid        (wdata_valid),
    .byte_take          (byte_take),
    .req_ready          (req_ready),
    .rsp_word           (rsp_word),
    .rsp_valid          (rsp_valid),
    .rsp_error          (rsp_error),
    .rsp_byte           (rsp_byte),
    .rsp_byte_valid     (rsp_byte_valid),
    .analog_sel_valid   (analog_sel_valid),
    .analog_sel_index   (analog_sel_index),
    .analog_input_value (analog_input_value),
    .path_go            (path_go),
    .path_length        (path_length)
  );
  mrma_analog_src #(.VALUE(AV)) u_analog
  (
    .chan_index         (analog_sel_index),
    .analog_input_value (analog_input_value)
  );
  initial
  begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  task report_and_stop;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task xfer(input logic w, input logic [15:0] a, input logic [7:0] n, input logic [15:0] d);
    @(negedge core_clk);
    {req_valid, req_write, req_addr, req_count} = {1'b1, w, a, n};
    @(negedge core_clk);
    req_valid = 0;
    for (i = 0; w && i < n; i++)
    begin
      {wdata_valid, req_wdata} = {1'b1, d + 16'(i)};
      @(negedge core_clk);
    end
    wdata_valid = 0;
    for (i = 0; i < 40 && req_ready !== 1'b1; i++)
      @(negedge core_clk);
    if (req_ready !== 1'b1)
      n_fail++;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (path_go === 1'b1)
      n_go++;
    if (rsp_valid === 1'b1 && exp_q.size() > 0)
      check(rsp_word, exp_q.pop_front());
    if (cyc > 3000)
    begin
      n_fail++;
      report_and_stop;
    end
  end
  initial
  begin
    {reset_n, req_valid, req_write, wdata_valid, byte_take} = 5'h00;
    {req_addr, req_count, req_wdata} = 40'h0;
    rnd = 16'($urandom(2));
    repeat (20) @(negedge core_clk);
    reset_n = 1;
    exp_q = {16'h0011, 16'h2233};
    xfer(1'b0, 16'hD73C, 8'h02, 16'h0000);
    exp_q.push_back(16'h2233);
    xfer(1'b0, 16'hD73D, 8'h01, 16'h0000);
    @(negedge core_clk);
    check({8'h00, rsp_byte}, 16'h0022);
    check({15'h0, rsp_byte_valid}, 16'h0001);
    byte_take = 1;
    @(negedge core_clk);
    check({8'h00, rsp_byte}, 16'h0033);
    @(negedge core_clk);
    byte_take = 0;
    check({15'h0, rsp_byte_valid}, 16'h0000);
    exp_q = {exp_q, AV[31:16], AV[15:0], AV1[31:16], AV1[15:0]};
    xfer(1'b0, 16'h0000, 8'h04, 16'h0000);
    xfer(1'b1, 16'hECF0, 8'h01, 16'h0004);
    xfer(1'b1, 16'hECEC, 8'h04, rnd);
    exp_q = {exp_q, rnd, rnd + 16'h1, rnd + 16'h2, rnd + 16'h3};
    xfer(1'b0, 16'hECEC, 8'h04, 16'h0000);
    check({15'h0, rsp_error}, 16'h0000);
    xfer(1'b0, 16'hECEE, 8'h01, 16'h0000);
    @(negedge core_clk);
    check({15'h0, rsp_error}, 16'h0001);
    xfer(1'b1, 16'hECF4, 8'h01, ~rnd);
    exp_q = {exp_q, ~rnd, 16'h0004};
    xfer(1'b0, 16'hECF4, 8'h01, 16'h0000);
    xfer(1'b0, 16'hECF0, 8'h01, 16'h0000);
    xfer(1'b1, 16'hECF2, 8'h01, 16'h0001);
    check(path_length, 16'h0004);
    exp_q.push_back(16'h8000);
    xfer(1'b0, 16'hECF6, 8'h01, 16'h0000);
    @(negedge core_clk);
    check(16'(exp_q.size()), 16'h0000);
    check(16'(n_go), 16'h0001);
    report_and_stop;
  end
endmodule // test_mrma_top
`default_nettype wire
